// ---- core/paired_timer.v ----
// Two chainable pairs of 16-bit timers with gating, prescaler and period match.
//
// Notes on behaviour
// - Each pair runs as one 32-bit timer or two 16-bit timers.
// - Chained pair offers 32-bit timer, 32-bit synchronous counter and 32-bit gated accumulation.
// - Each 16-bit timer can time or synchronously count external edges.
// - ADC trigger comes only from upper timer of second pair.
// - In 32-bit mode upper control ignored; lower control, clock, gate used.
// - In 32-bit mode the match raises the upper timer's interrupt flag.
// - Chain bit 3 of lower control selects 32-bit operation.
// - Upper period register is the high word of the 32-bit period.
// - In 32-bit mode interrupt when 32-bit count equals 32-bit period.
// - Upper count register holds high word, lower holds low word.
// - In 16-bit mode each timer compares against its own period.
// - Run bit 15 starts the timer when set, stops it when clear.
// - Idle-halt bit 13 stops the timer in Idle when set.
// - Gate bit 6 enables gated accumulation, ignored with external clock.
// - Prescale bits 5-4 divide by 256, 64, 8 or 1.
// - Clock-source bit 1 counts rising edges of the external clock pin.
// - Any control write while running resets the prescale counter.
// - Timers may keep running in Idle and Sleep when configured.
//
// Local design decisions: the plain strobed port and the register addresses.
`include "paired_timer_regs.vh"

module paired_timer (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire [4:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   input  wire        idle_mode,
   input  wire        sleep_mode,
   input  wire [3:0]  ext_timer_clock_pin,
   input  wire [3:0]  gate_pin,
   output reg  [3:0]  timer_irq,
   output reg         adc_trigger
);

   // ---------------------------------------------------------------
   // Input synchronisers and edge detection
   // ---------------------------------------------------------------

   reg [3:0] clk_meta_q;
   reg [3:0] clk_sync_q;
   reg [3:0] clk_prev_q;
   reg [3:0] gate_meta_q;
   reg [3:0] gate_sync_q;
   reg [3:0] gate_prev_q;

   // Pins pass two flops; only the second stage feeds the edge detectors.
   // The previous-value flops reset low like an idle pin, so no false edge
   // is seen when reset is released.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_meta_q  <= 4'h0;
         clk_sync_q  <= 4'h0;
         clk_prev_q  <= 4'h0;
         gate_meta_q <= 4'h0;
         gate_sync_q <= 4'h0;
         gate_prev_q <= 4'h0;
      end else begin
         clk_meta_q  <= ext_timer_clock_pin;
         clk_sync_q  <= clk_meta_q;
         clk_prev_q  <= clk_sync_q;
         gate_meta_q <= gate_pin;
         gate_sync_q <= gate_meta_q;
         gate_prev_q <= gate_sync_q;
      end
   end

   // Rising clock edges and falling gate edges, each one cycle wide.
   wire [3:0] ext_rise  = clk_sync_q & ~clk_prev_q;
   wire [3:0] gate_fall = gate_prev_q & ~gate_sync_q;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------

   reg [15:0] ctrl_q   [0:3];
   reg [15:0] count_q  [0:3];
   reg [15:0] period_q [0:3];
   reg [7:0]  pre_q    [0:3];
   reg [3:0]  flag_q;
   reg [3:0]  irq_en_q;
   reg        sleep_run_q;

   // Index 0/2 are the lower timers, 1/3 the upper timers.
   // Upper control words are stored even while chained; they simply have no effect.
   wire chain_a = ctrl_q[0][`CHAIN_BIT];
   wire chain_b = ctrl_q[2][`CHAIN_BIT];
   wire [3:0] chained = {chain_b, chain_b, chain_a, chain_a};

   // Control word that governs each timer; upper follows lower when chained.
   wire [15:0] eff_ctrl [0:3];
   assign eff_ctrl[0] = ctrl_q[0];
   assign eff_ctrl[1] = chain_a ? ctrl_q[0] : ctrl_q[1];
   assign eff_ctrl[2] = ctrl_q[2];
   assign eff_ctrl[3] = chain_b ? ctrl_q[2] : ctrl_q[3];

   // ---------------------------------------------------------------
   // Pin routing per timer
   // ---------------------------------------------------------------

   // In 16-bit mode each timer listens to its own clock and gate pins.
   // A chained pair takes both halves from the lower timer's pins, so the
   // upper pins of that pair are ignored while the chain bit is set.
   wire [3:0] rise_sel;
   wire [3:0] fall_sel;
   wire [3:0] gate_sel;
   assign rise_sel[0] = ext_rise[0];
   assign rise_sel[1] = chain_a ? ext_rise[0] : ext_rise[1];
   assign rise_sel[2] = ext_rise[2];
   assign rise_sel[3] = chain_b ? ext_rise[2] : ext_rise[3];
   assign fall_sel[0] = gate_fall[0];
   assign fall_sel[1] = chain_a ? gate_fall[0] : gate_fall[1];
   assign fall_sel[2] = gate_fall[2];
   assign fall_sel[3] = chain_b ? gate_fall[2] : gate_fall[3];
   assign gate_sel[0] = gate_sync_q[0];
   assign gate_sel[1] = chain_a ? gate_sync_q[0] : gate_sync_q[1];
   assign gate_sel[2] = gate_sync_q[2];
   assign gate_sel[3] = chain_b ? gate_sync_q[2] : gate_sync_q[3];

   // ---------------------------------------------------------------
   // Count enables per timer
   // ---------------------------------------------------------------

   reg [3:0] tick;
   reg [3:0] pre_hit;
   reg [3:0] gate_ok;
   reg [3:0] gate_evt;
   reg [3:0] base_en;
   reg [7:0] term;
   reg       src_ext;
   reg       gated;
   reg       gate_lvl;
   integer   i;
   integer   j;

   // Pick source, gate and prescale for each timer from its governing control.
   // Every intermediate starts from a default so that no path leaves a latch.
   always @* begin
      tick     = 4'h0;
      pre_hit  = 4'h0;
      gate_ok  = 4'h0;
      gate_evt = 4'h0;
      base_en  = 4'h0;
      term     = `PRESCALE_DIV1;
      src_ext  = 1'b0;
      gated    = 1'b0;
      gate_lvl = 1'b0;
      for (j = 0; j < 4; j = j + 1) begin
         // Chained upper halves see the lower pins through the routing above.
         src_ext  = eff_ctrl[j][`CLK_SRC_BIT];
         gate_lvl = gate_sel[j];
         gated    = eff_ctrl[j][`GATE_BIT] & ~src_ext;
         case (eff_ctrl[j][`PRESCALE_HI_BIT:`PRESCALE_LO_BIT])
            2'b11:   term = `PRESCALE_DIV256;
            2'b10:   term = `PRESCALE_DIV64;
            2'b01:   term = `PRESCALE_DIV8;
            default: term = `PRESCALE_DIV1;
         endcase
         // Run bit, idle halt and sleep keep-alive decide whether it runs.
         // The core clock is gone in Sleep, so only an external source may
         // keep counting there, and only when software allowed it.
         base_en[j] = eff_ctrl[j][`RUN_BIT]
                      & ~(idle_mode & eff_ctrl[j][`IDLE_HALT_BIT])
                      & ~(sleep_mode & ~(sleep_run_q & src_ext));
         // External edges or core clock feed the prescaler.
         tick[j]     = base_en[j] & (src_ext ? rise_sel[j] : 1'b1);
         gate_ok[j]  = ~gated | gate_lvl;
         pre_hit[j]  = tick[j] & gate_ok[j] & (pre_q[j] == term);
         gate_evt[j] = base_en[j] & gated & fall_sel[j];
      end
   end

   // ---------------------------------------------------------------
   // Period comparison
   // ---------------------------------------------------------------

   // Both pairs always form their 32-bit words; the chain bit only decides
   // which compare result the counters and flags listen to.
   wire [31:0] cnt32_a = {count_q[1], count_q[0]};
   wire [31:0] cnt32_b = {count_q[3], count_q[2]};
   wire [31:0] per32_a = {period_q[1], period_q[0]};
   wire [31:0] per32_b = {period_q[3], period_q[2]};
   wire match32_a = (cnt32_a == per32_a);
   wire match32_b = (cnt32_b == per32_b);
   wire [3:0] match16;
   assign match16[0] = (count_q[0] == period_q[0]);
   assign match16[1] = (count_q[1] == period_q[1]);
   assign match16[2] = (count_q[2] == period_q[2]);
   assign match16[3] = (count_q[3] == period_q[3]);

   // Increment step and match event per timer; chained pairs step as one.
   // Sharing the lower step keeps the two halves from ever drifting apart.
   reg [3:0] period_evt;
   reg [3:0] step;
   always @* begin
      step = 4'h0;
      period_evt = 4'h0;
      if (chain_a) begin
         step[0] = pre_hit[0];
         step[1] = pre_hit[0];
         period_evt[1] = pre_hit[0] & match32_a;
      end else begin
         step[1:0] = pre_hit[1:0];
         period_evt[1:0] = pre_hit[1:0] & match16[1:0];
      end
      if (chain_b) begin
         step[2] = pre_hit[2];
         step[3] = pre_hit[2];
         period_evt[3] = pre_hit[2] & match32_b;
      end else begin
         step[3:2] = pre_hit[3:2];
         period_evt[3:2] = pre_hit[3:2] & match16[3:2];
      end
   end

   // Gate falling edges flag the timer that carries the interrupt.
   wire [3:0] gate_flag;
   assign gate_flag[0] = gate_evt[0] & ~chain_a;
   assign gate_flag[1] = chain_a ? gate_evt[0] : gate_evt[1];
   assign gate_flag[2] = gate_evt[2] & ~chain_b;
   assign gate_flag[3] = chain_b ? gate_evt[2] : gate_evt[3];
   // Hardware events that set a flag this cycle.
   wire [3:0] set_flag = period_evt | gate_flag;

   // ---------------------------------------------------------------
   // Counters, prescalers and register writes
   // ---------------------------------------------------------------

   // Write strobes decoded per register; a plain compare per offset keeps widths exact.
   wire [3:0] sel_ctrl;
   wire [3:0] sel_cnt;
   wire [3:0] sel_per;
   assign sel_ctrl[0] = reg_wr & (reg_addr == `CTRL_LOW_A_OFF);
   assign sel_ctrl[1] = reg_wr & (reg_addr == `CTRL_HIGH_A_OFF);
   assign sel_ctrl[2] = reg_wr & (reg_addr == `CTRL_LOW_B_OFF);
   assign sel_ctrl[3] = reg_wr & (reg_addr == `CTRL_HIGH_B_OFF);
   assign sel_cnt[0]  = reg_wr & (reg_addr == `COUNT_LOW_A_OFF);
   assign sel_cnt[1]  = reg_wr & (reg_addr == `COUNT_HIGH_A_OFF);
   assign sel_cnt[2]  = reg_wr & (reg_addr == `COUNT_LOW_B_OFF);
   assign sel_cnt[3]  = reg_wr & (reg_addr == `COUNT_HIGH_B_OFF);
   assign sel_per[0]  = reg_wr & (reg_addr == `PERIOD_LOW_A_OFF);
   assign sel_per[1]  = reg_wr & (reg_addr == `PERIOD_HIGH_A_OFF);
   assign sel_per[2]  = reg_wr & (reg_addr == `PERIOD_LOW_B_OFF);
   assign sel_per[3]  = reg_wr & (reg_addr == `PERIOD_HIGH_B_OFF);

   // Control, period, prescaler and count registers. A software write to a
   // count wins over the increment, so a reload is never lost.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 4; i = i + 1) begin
            ctrl_q[i]   <= `CTRL_RESET;
            count_q[i]  <= `COUNT_RESET;
            period_q[i] <= `PERIOD_RESET;
            pre_q[i]    <= 8'h00;
         end
      end else begin
         for (i = 0; i < 4; i = i + 1) begin
            if (sel_ctrl[i]) begin
               ctrl_q[i] <= reg_wdata & `CTRL_WRITE_MASK;
            end
            if (sel_per[i]) begin
               period_q[i] <= reg_wdata;
            end
            // A control write while running restarts the prescaler.
            if (sel_ctrl[i] & ctrl_q[i][`RUN_BIT]) begin
               pre_q[i] <= 8'h00;
            end else if (pre_hit[i]) begin
               pre_q[i] <= 8'h00;
            end else if (tick[i] & gate_ok[i]) begin
               pre_q[i] <= pre_q[i] + 8'h01;
            end
         end
         // Software writes to a count win over the increment.
         for (i = 0; i < 4; i = i + 1) begin
            if (sel_cnt[i]) begin
               count_q[i] <= reg_wdata;
            end else if (step[i]) begin
               if (chained[i]) begin
                  if ((i < 2) ? match32_a : match32_b) begin
                     count_q[i] <= 16'h0000;
                  end else if ((i & 1) == 0) begin
                     count_q[i] <= count_q[i] + 16'h0001;
                  end else if (count_q[i & 2] == 16'hffff) begin
                     // Upper half steps only when the lower half rolls over.
                     count_q[i] <= count_q[i] + 16'h0001;
                  end
               end else if (match16[i]) begin
                  count_q[i] <= 16'h0000;
               end else begin
                  count_q[i] <= count_q[i] + 16'h0001;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Flags, enables, power control and outputs
   // ---------------------------------------------------------------

   // Writing zero to a flag bit clears it; writing one leaves it alone.
   wire flag_wr  = reg_wr & (reg_addr == `IRQ_FLAG_OFF);
   wire [3:0] clr_flag = flag_wr ? ~reg_wdata[3:0] : 4'h0;

   // Flags are cleared by writing zero; a new event in that cycle wins.
   // The interrupt output is taken from the next flag value so that it
   // rises on the same edge as the flag.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q      <= 4'h0;
         irq_en_q    <= 4'h0;
         sleep_run_q <= 1'b0;
         timer_irq   <= 4'h0;
         adc_trigger <= 1'b0;
      end else begin
         flag_q <= (flag_q & ~clr_flag) | set_flag;
         if (reg_wr & (reg_addr == `IRQ_ENABLE_OFF)) begin
            irq_en_q <= reg_wdata[3:0];
         end
         if (reg_wr & (reg_addr == `POWER_CTRL_OFF)) begin
            sleep_run_q <= reg_wdata[0];
         end
         timer_irq   <= ((flag_q & ~clr_flag) | set_flag) & irq_en_q;
         adc_trigger <= period_evt[3];
      end
   end

   // Register read mux, data appears in the cycle after the strobe.
   reg [15:0] rd_mux;
   always @* begin
      case (reg_addr)
         `CTRL_LOW_A_OFF:    rd_mux = ctrl_q[0];
         `CTRL_HIGH_A_OFF:   rd_mux = ctrl_q[1];
         `CTRL_LOW_B_OFF:    rd_mux = ctrl_q[2];
         `CTRL_HIGH_B_OFF:   rd_mux = ctrl_q[3];
         `COUNT_LOW_A_OFF:   rd_mux = count_q[0];
         `COUNT_HIGH_A_OFF:  rd_mux = count_q[1];
         `COUNT_LOW_B_OFF:   rd_mux = count_q[2];
         `COUNT_HIGH_B_OFF:  rd_mux = count_q[3];
         `PERIOD_LOW_A_OFF:  rd_mux = period_q[0];
         `PERIOD_HIGH_A_OFF: rd_mux = period_q[1];
         `PERIOD_LOW_B_OFF:  rd_mux = period_q[2];
         `PERIOD_HIGH_B_OFF: rd_mux = period_q[3];
         `IRQ_FLAG_OFF:      rd_mux = {12'h000, flag_q};
         `IRQ_ENABLE_OFF:    rd_mux = {12'h000, irq_en_q};
         `POWER_CTRL_OFF:    rd_mux = {15'h0000, sleep_run_q};
         default:            rd_mux = 16'h0000;
      endcase
   end

   // Read data register; it holds a value only in the cycle after a read
   // strobe and returns to zero otherwise.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule

// ---- core/paired_timer_regs.vh ----
// Register offsets, field positions, reset values and prescale counts for the paired timers.
`ifndef PAIRED_TIMER_REGS_VH
`define PAIRED_TIMER_REGS_VH

// Register word offsets: controls, counts and periods of both pairs, then interrupt flags, interrupt enables and power control.
`define CTRL_LOW_A_OFF    5'h00
`define CTRL_HIGH_A_OFF   5'h01
`define CTRL_LOW_B_OFF    5'h02
`define CTRL_HIGH_B_OFF   5'h03
`define COUNT_LOW_A_OFF   5'h04
`define COUNT_HIGH_A_OFF  5'h05
`define COUNT_LOW_B_OFF   5'h06
`define COUNT_HIGH_B_OFF  5'h07
`define PERIOD_LOW_A_OFF  5'h08
`define PERIOD_HIGH_A_OFF 5'h09
`define PERIOD_LOW_B_OFF  5'h0a
`define PERIOD_HIGH_B_OFF 5'h0b
`define IRQ_FLAG_OFF      5'h0c
`define IRQ_ENABLE_OFF    5'h0d
`define POWER_CTRL_OFF    5'h0e

// Control register field positions.
`define RUN_BIT           15
`define IDLE_HALT_BIT     13
`define GATE_BIT          6
`define PRESCALE_HI_BIT   5
`define PRESCALE_LO_BIT   4
`define CHAIN_BIT         3
`define CLK_SRC_BIT       1
`define CTRL_WRITE_MASK   16'ha07a

// Reset values.
`define CTRL_RESET        16'h0000
`define COUNT_RESET       16'h0000
`define PERIOD_RESET      16'hffff

// Prescaler terminal counts (divide ratio minus one).
`define PRESCALE_DIV1     8'h00
`define PRESCALE_DIV8     8'h07
`define PRESCALE_DIV64    8'h3f
`define PRESCALE_DIV256   8'hff

`endif

// ---- verif/paired_timer_checker.sv ----
// Port-level assertions for the paired timer block.
`include "paired_timer_regs.vh"
module paired_timer_checker (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic [4:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [3:0]  timer_irq,
   input wire logic        adc_trigger
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] run_q, h1_q, h2_q, h3_q;
   wire  [3:0] recent = run_q | h1_q | h2_q | h3_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Tracks the run bits software wrote over the last few cycles.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q <= 4'h0;
         h1_q  <= 4'h0;
         h2_q  <= 4'h0;
         h3_q  <= 4'h0;
      end
      else begin
         if (reg_wr && reg_addr < 5'h04) run_q[reg_addr[1:0]] <= reg_wdata[15];
         h1_q <= run_q;
         h2_q <= h1_q;
         h3_q <= h2_q;
      end
   end
   property p_read_quiet;
      !reg_rd |=> reg_rdata == 16'h0000;
   endproperty
   a_read_quiet: assert property (p_read_quiet)
      else $error("read data not zero outside a read");
   property p_reset_quiet;
      $rose(rst_n) |-> timer_irq == 4'h0 && !adc_trigger;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs active right after reset");
   property p_ctrl_mask;
      (reg_wr && reg_addr < 5'h04) ##1 !reg_wr ##1 (reg_rd && reg_addr == $past(reg_addr, 2))
      |=> reg_rdata == ($past(reg_wdata, 3) & `CTRL_WRITE_MASK);
   endproperty
   a_ctrl_mask: assert property (p_ctrl_mask)
      else $error("control readback wrong");
   property p_period_back;
      (reg_wr && reg_addr[4:2] == 3'b010) ##1 !reg_wr ##1
      (reg_rd && reg_addr == $past(reg_addr, 2)) |=> reg_rdata == $past(reg_wdata, 3);
   endproperty
   a_period_back: assert property (p_period_back)
      else $error("period readback wrong");
   property p_irq_mask;
      reg_wr && reg_addr == `IRQ_ENABLE_OFF |=> ##1 (timer_irq & ~$past(reg_wdata[3:0], 2)) == 4'h0;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("interrupt raised while disabled");
   property p_adc_src;
      adc_trigger |-> recent[3] || recent[2];
   endproperty
   a_adc_src: assert property (p_adc_src)
      else $error("trigger while second pair stopped");
   property p_irq_lo_src;
      $rose(timer_irq[0]) |-> recent[0];
   endproperty
   a_irq_lo_src: assert property (p_irq_lo_src)
      else $error("lower interrupt while stopped");
   property p_irq_hi_src;
      $rose(timer_irq[1]) |-> recent[1] || recent[0];
   endproperty
   a_irq_hi_src: assert property (p_irq_hi_src)
      else $error("upper interrupt while pair stopped");
endmodule

bind paired_timer paired_timer_checker i_checker (.core_clk(core_clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .timer_irq(timer_irq), .adc_trigger(adc_trigger));

// ---- verif/ext_pin_model.sv ----
// Behavioural model of the external timer clock and gate pins.
module ext_pin_model (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] clk_en,
   input  wire logic [7:0] half_cycles,
   input  wire logic [3:0] gate_cmd,
   output logic [3:0]      ext_timer_clock_pin,
   output logic [3:0]      gate_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] tick_q;
   wire        flip = (tick_q + 8'h01) >= half_cycles;
   // Enabled clock pins toggle every half_cycles edges; pins not selected stand low.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q              <= 8'h00;
         ext_timer_clock_pin <= 4'h0;
         gate_pin            <= 4'h0;
      end
      else begin
         tick_q              <= flip ? 8'h00 : tick_q + 8'h01;
         ext_timer_clock_pin <= (flip ? ~ext_timer_clock_pin : ext_timer_clock_pin) & clk_en;
         gate_pin            <= gate_cmd;
      end
   end
endmodule

// ---- verif/paired_timer_tb.sv ----
// Self-checking bench for the paired timer block.
`include "paired_timer_regs.vh"
module paired_timer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk, rst_n, reg_wr, reg_rd, idle_mode, sleep_mode, adc_trigger;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rd_val, d;
   logic [3:0]  clk_en, gate_cmd, ext_pins, gate_pins, timer_irq;
   logic [7:0]  half_cycles;
   int          n_mismatch = 0, checks_done = 0, cyc = 0, n_adc = 0, t0, p, h;
   paired_timer i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .idle_mode(idle_mode), .sleep_mode(sleep_mode), .ext_timer_clock_pin(ext_pins),
      .gate_pin(gate_pins), .timer_irq(timer_irq), .adc_trigger(adc_trigger));
   ext_pin_model i_pins (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
      .half_cycles(half_cycles), .gate_cmd(gate_cmd), .ext_timer_clock_pin(ext_pins),
      .gate_pin(gate_pins));
   // Free-running clock.
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Cycle count, trigger pulse count and hang limit.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (adc_trigger === 1'b1) n_adc <= n_adc + 1;
      if (cyc == 30000) begin
         n_mismatch = n_mismatch + 1;
         complete_run();
      end
   end
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [4:0] a, logic [15:0] v);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [4:0] a);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   task automatic wait_irq(int b);
      int n;
      n = 0;
      while (timer_irq[b] !== 1'b1 && n < 6000) begin
         @(posedge core_clk);
         n++;
      end
      check("interrupt wait", 16'(n < 6000), 16'h0001);
   endtask
   // Measures the spacing of two matches, clearing the flag in between.
   task automatic measure(int b, int exp);
      wait_irq(b);
      t0 = cyc;
      wr(`IRQ_FLAG_OFF, 16'h0000);
      repeat (2) @(posedge core_clk);
      wait_irq(b);
      check("match interval", 16'(cyc - t0), 16'(exp));
   endtask
   task automatic start(int t, logic [15:0] ctrl, logic [15:0] per);
      wr(5'(`PERIOD_LOW_A_OFF + t), per);
      wr(`IRQ_ENABLE_OFF, 16'h000f);
      wr(`IRQ_FLAG_OFF, 16'h0000);
      wr(5'(`CTRL_LOW_A_OFF + t), ctrl);
   endtask
   task automatic stop_all;
      for (int i = 0; i < 4; i++) begin
         wr(5'(i), 16'h0000);
         wr(5'(4 + i), 16'h0000);
      end
   endtask
   function automatic int interval(int ps, int per, int step);
      int div[4] = '{1, 8, 64, 256};
      return (per + 1) * div[ps] * step;
   endfunction
   // Main sequence.
   initial begin
      {rst_n, reg_wr, reg_rd, idle_mode, sleep_mode} = 5'h00;
      {reg_addr, reg_wdata, clk_en, gate_cmd} = 29'h0000_0000;
      half_cycles = 8'h03;
      void'($urandom(32'h2e48));
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 16; a++) begin
         rd(5'(a));
         check("reset value", rd_val, (a > 7 && a < 12) ? 16'hffff : 16'h0000);
      end
      for (int i = 0; i < 8; i++) begin
         d = 16'($urandom);
         wr(5'(i % 4), d);
         rd(5'(i % 4));
         check("control", rd_val, d & `CTRL_WRITE_MASK);
      end
      stop_all();
      for (int i = 0; i < 4; i++) begin
         d = 16'($urandom);
         wr(5'(`PERIOD_LOW_A_OFF + i), d);
         rd(5'(`PERIOD_LOW_A_OFF + i));
         check("period", rd_val, d);
      end
      for (int ps = 0; ps < 4; ps++) begin
         p = 4 + $urandom_range(5);
         start(0, 16'h8000 | 16'(ps << 4), 16'(p));
         measure(0, interval(ps, p, 1));
         stop_all();
      end
      for (int m = 0; m < 3; m++) begin
         idle_mode  <= (m < 2);
         sleep_mode <= (m == 2);
         start(0, (m == 0) ? 16'ha000 : 16'h8000, 16'h0004);
         if (m == 1) measure(0, 5);
         else begin
            repeat (40) @(posedge core_clk);
            check("halted", 16'(timer_irq[0]), 16'h0000);
         end
         idle_mode  <= 1'b0;
         sleep_mode <= 1'b0;
         stop_all();
      end
      h = 2 + $urandom_range(3);
      half_cycles <= 8'(h);
      clk_en      <= 4'h2;
      sleep_mode  <= 1'b1;
      wr(`POWER_CTRL_OFF, 16'h0001);
      p = 4 + $urandom_range(5);
      start(1, 16'h8042, 16'(p));
      measure(1, interval(0, p, 2 * h));
      sleep_mode <= 1'b0;
      clk_en <= 4'h0;
      stop_all();
      start(0, 16'h8040, 16'hffff);
      gate_cmd <= 4'h1;
      repeat (20) @(posedge core_clk);
      check("gate high", 16'(timer_irq[0]), 16'h0000);
      gate_cmd <= 4'h0;
      repeat (8) @(posedge core_clk);
      check("gate fall", 16'(timer_irq[0]), 16'h0001);
      stop_all();
      check("no trigger", 16'(n_adc), 16'h0000);
      wr(`CTRL_HIGH_B_OFF, 16'h0030);
      wr(`PERIOD_HIGH_B_OFF, 16'h0000);
      p = 4 + $urandom_range(5);
      start(2, 16'h8008, 16'(p));
      measure(3, interval(0, p, 1));
      check("lower flag", 16'(timer_irq[2]), 16'h0000);
      check("trigger seen", 16'(n_adc > 0), 16'h0001);
      stop_all();
      wr(`COUNT_LOW_B_OFF, 16'hfffe);
      wr(`CTRL_LOW_B_OFF, 16'h8008);
      repeat (10) @(posedge core_clk);
      wr(`CTRL_LOW_B_OFF, 16'h0008);
      rd(`COUNT_HIGH_B_OFF);
      check("carry", rd_val, 16'h0001);
      complete_run();
   end
endmodule
